// *** lrbt_pkg.sv ***
// package: constants and types for the long range binary timer
package lrbt_pkg;
  localparam int unsigned CNT_WIDTH      = 8;
  localparam int unsigned TB_BIT         = 0;
  localparam int unsigned MAIN_BIT       = 7;
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned TB_PERIOD_NS   = 2000;
  localparam int unsigned TB_PERIOD_CYC  = (TB_PERIOD_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned TB_HALF_CYC    = TB_PERIOD_CYC / 2;
  localparam logic [7:0]  CNT_RESET      = 8'h00;
  localparam logic [15:0] DIV_RESET      = 16'h0000;
  localparam logic [15:0] DIV_LAST       = 16'(TB_PERIOD_CYC - 1);
  localparam logic [15:0] DIV_LOW_FROM   = 16'(TB_HALF_CYC);
  typedef enum logic [1:0] {
    LRBT_IDLE = 2'b01,
    LRBT_RUN  = 2'b10
  } lrbt_state_type;
endpackage

// *** lrbt_if.sv ***
// interface: time-base handoff between control and counter stage
`timescale 1ns/1ps
`default_nettype none
interface lrbt_if;
  logic clear;
  logic count_edge;
  logic [7:0] count;
  modport ctrl (output clear, output count_edge, input count);
  modport cnt  (input clear, input count_edge, output count);
endinterface
`default_nettype wire

// *** lrbt_counter.sv ***
// ripple counter stage model: eight-bit binary count, cleared by reset
`timescale 1ns/1ps
`default_nettype none
module lrbt_counter (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  lrbt_if.cnt       bus
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;

  // count advances once per count_edge pulse: a falling external edge, or the close of an internal period
  always_comb begin
    cnt_next = cnt_reg;
    if (bus.clear) begin
      cnt_next = lrbt_pkg::CNT_RESET;
    end else if (bus.count_edge) begin
      cnt_next = cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= lrbt_pkg::CNT_RESET;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign bus.count = cnt_reg;
endmodule
`default_nettype wire

// *** lrbt_timer.sv ***
// top: trigger/reset controlled long-delay binary timer
`timescale 1ns/1ps
`default_nettype none
module lrbt_timer (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic trigger_in,
  input  wire logic reset_in,
  input  wire logic feedback_link_switch,
  input  wire logic continuous_mode,
  input  wire logic ext_clock_sel,
  input  wire logic time_base_in,
  output logic      output_interval_o,
  output logic      output_interval_oe,
  output logic      stage0_o,
  output logic      stage0_oe,
  output logic      time_base_o,
  output logic      time_base_oe
);
  lrbt_if link ();

  // two-flop synchronisers for every pin input
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic [5:0] sync1_next;
  logic [5:0] sync2_next;
  logic       trig_s;
  logic       rst_s;
  logic       fb_s;
  logic       cont_s;
  logic       extsel_s;
  logic       tbin_s;

  always_comb begin
    sync1_next = {time_base_in, ext_clock_sel, continuous_mode,
                  feedback_link_switch, reset_in, trigger_in};
    sync2_next = sync1_reg;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  assign trig_s   = sync2_reg[0];
  assign rst_s    = sync2_reg[1];
  assign fb_s     = sync2_reg[2];
  assign cont_s   = sync2_reg[3];
  assign extsel_s = sync2_reg[4];
  assign tbin_s   = sync2_reg[5];

  // edge detection and power-up self-trigger
  logic       trig_d_reg;
  logic       trig_d_next;
  logic       rst_d_reg;
  logic       rst_d_next;
  logic       main_d_reg;
  logic       main_d_next;
  logic       tbin_d_reg;
  logic       tbin_d_next;
  logic [2:0] boot_reg;
  logic [2:0] boot_next;
  logic       trig_rise;
  logic       rst_rise;
  logic       fb_rise;

  always_comb begin
    trig_d_next = trig_s;
    rst_d_next  = rst_s;
    main_d_next = link.count[lrbt_pkg::MAIN_BIT];
    tbin_d_next = tbin_s;
    // boot window waits until continuous_mode has crossed both sync flops
    boot_next   = {boot_reg[1:0], 1'b0};
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_d_reg <= 1'b0;
      rst_d_reg  <= 1'b0;
      main_d_reg <= 1'b0;
      tbin_d_reg <= 1'b0;
      boot_reg   <= 3'h1;
    end else begin
      trig_d_reg <= trig_d_next;
      rst_d_reg  <= rst_d_next;
      main_d_reg <= main_d_next;
      tbin_d_reg <= tbin_d_next;
      boot_reg   <= boot_next;
    end
  end

  assign trig_rise = (trig_s & ~trig_d_reg) | (boot_reg[2] & cont_s);
  assign rst_rise  = rst_s & ~rst_d_reg;
  // timing pin rises as bit 7 sets; feedback treats it as a reset pulse
  assign fb_rise   = fb_s & ~main_d_reg & link.count[lrbt_pkg::MAIN_BIT];

  // control flip-flop: set by trigger, cleared by reset
  lrbt_pkg::lrbt_state_type state_reg;
  lrbt_pkg::lrbt_state_type state_next;
  logic                     start;

  always_comb begin
    state_next = state_reg;
    start      = 1'b0;
    case (state_reg)
      lrbt_pkg::LRBT_IDLE: begin
        if (trig_rise) begin
          state_next = lrbt_pkg::LRBT_RUN;
          start      = 1'b1;
        end
      end
      lrbt_pkg::LRBT_RUN: begin
        // trigger outranks a coincident reset, and restarts nothing
        if ((rst_rise | fb_rise) & ~trig_rise) begin
          state_next = lrbt_pkg::LRBT_IDLE;
        end // further triggers ignored here
      end
      default: state_next = lrbt_pkg::LRBT_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= lrbt_pkg::LRBT_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // internal time base divider, runs only while triggered
  logic [15:0] div_reg;
  logic [15:0] div_next;
  logic        running;
  logic        tb_level;
  logic        int_fall;
  logic        ext_fall;

  assign running = (state_reg == lrbt_pkg::LRBT_RUN);

  always_comb begin
    div_next = lrbt_pkg::DIV_RESET;
    if (running && !start) begin
      div_next = (div_reg == lrbt_pkg::DIV_LAST) ? lrbt_pkg::DIV_RESET : div_reg + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= lrbt_pkg::DIV_RESET;
    end else begin
      div_reg <= div_next;
    end
  end

  // internal base: high first half, low second half of each period
  // count at the close of each period, so 128 counts span 128 full periods
  assign int_fall = running & (div_reg == lrbt_pkg::DIV_LAST);
  // external clock (or a previous stage's output) counts on its falling edge
  assign ext_fall = running & tbin_d_reg & ~tbin_s;
  assign tb_level = ~running | (div_reg < lrbt_pkg::DIV_LOW_FROM);

  // counter gated by control flip-flop, cleared while at rest
  assign link.clear      = ~running | start;
  assign link.count_edge = extsel_s ? ext_fall : int_fall;

  lrbt_counter u_counter (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .bus     (link)
  );

  // open-collector outputs: enable pulls the pin low, registered
  logic [2:0] out_reg;
  logic [2:0] out_next;

  always_comb begin
    out_next[0] = running & link.count[lrbt_pkg::TB_BIT];
    out_next[1] = ~start & running & ~link.count[lrbt_pkg::MAIN_BIT];
    out_next[1] = out_next[1] | start;
    out_next[2] = running & ~(extsel_s | tb_level);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= 3'h0;
    end else begin
      out_reg <= out_next;
    end
  end

  assign stage0_oe          = out_reg[0];
  assign stage0_o           = 1'b0;
  assign output_interval_oe = out_reg[1];
  assign output_interval_o  = 1'b0;
  assign time_base_oe       = out_reg[2];
  assign time_base_o        = 1'b0;
endmodule
`default_nettype wire

// *** lrbt_checker.sv ***
// checker: pin timing properties of the binary timer
`timescale 1ns/1ps
`default_nettype none
module lrbt_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic trigger_in,
  input wire logic reset_in,
  input wire logic feedback_link_switch,
  input wire logic continuous_mode,
  input wire logic ext_clock_sel,
  input wire logic time_base_in,
  input wire logic output_interval_o,
  input wire logic output_interval_oe,
  input wire logic stage0_o,
  input wire logic stage0_oe,
  input wire logic time_base_o,
  input wire logic time_base_oe
);
  localparam int FULL = 128 * lrbt_pkg::TB_PERIOD_CYC;
  int   run_reg, run_next, gap_reg, gap_next;
  logic s0_reg, idle;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // rest means no pin pulled low
  assign idle = !output_interval_oe && !stage0_oe && !time_base_oe;
  // low-stretch length and stage0 edge spacing
  always_comb begin
    run_next = output_interval_oe ? run_reg + 1 : 0;
    gap_next = (stage0_oe != s0_reg) ? 1 : gap_reg + 1;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= 0;
      gap_reg <= 0;
      s0_reg  <= 1'b0;
    end else begin
      run_reg <= run_next;
      gap_reg <= gap_next;
      s0_reg  <= stage0_oe;
    end
  end
  AST_START: assert property (
    $rose(trigger_in) && !reset_in && idle |-> ##[2:5] output_interval_oe) else $error("no start");
  AST_TRIG_WINS: assert property (
    $rose(trigger_in) && $rose(reset_in) && idle |-> ##[2:5] output_interval_oe[*8])
    else $error("reset beat trigger");
  AST_INTERVAL: assert property (
    $fell(output_interval_oe) && !ext_clock_sel |-> run_reg inside {[FULL-2:FULL+2]})
    else $error("interval length");
  AST_MONO_END: assert property (
    $fell(output_interval_oe) && feedback_link_switch |-> ##[1:4] idle[*8])
    else $error("no self reset");
  AST_ASTABLE: assert property (
    $fell(output_interval_oe) && !feedback_link_switch |-> ##[1:90] $changed(stage0_oe))
    else $error("count stopped");
  AST_RESET_PIN: assert property (
    $rose(reset_in) && !trigger_in |-> ##[2:6] idle) else $error("reset ignored");
  AST_STAGE_SQ: assert property (
    stage0_oe != s0_reg && output_interval_oe && $past(output_interval_oe, 100) && !ext_clock_sel
    |-> gap_reg == lrbt_pkg::TB_PERIOD_CYC) else $error("stage0 period");
  AST_TB_PULSE: assert property (
    $rose(time_base_oe) |-> ##39 time_base_oe ##1 !time_base_oe) else $error("time base pulse");
endmodule
bind lrbt_timer lrbt_checker lrbt_checker_i (.ref_clk, .rst_n, .trigger_in, .reset_in,
  .feedback_link_switch, .continuous_mode, .ext_clock_sel, .time_base_in, .output_interval_o,
  .output_interval_oe, .stage0_o, .stage0_oe, .time_base_o, .time_base_oe);
`default_nettype wire

// *** lrbt_far_src.sv ***
// far side: external clock on the time-base pin
`timescale 1ns/1ps
`default_nettype none
module lrbt_far_src #(
  parameter int HALF = 4
) (
  input  wire logic ref_clk,
  input  wire logic run,
  output var  logic clk_o
);
  int cnt = 0;
  initial clk_o = 1'b1;
  // parks high when stopped, as the pull-up would
  always @(posedge ref_clk) begin
    cnt <= (cnt + 1) % HALF;
    if (!run)
      clk_o <= 1'b1;
    else if (cnt == HALF - 1)
      clk_o <= !clk_o;
  end
endmodule
`default_nettype wire

// *** testbench.sv ***
// testbench: drives the timer and times its pins
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 0, rst_n = 0, trigger_in = 0, reset_in = 0;
  logic fb_sw = 0, cont_md = 1, ext_sel = 1, run_clk = 1;
  logic ext_clk, oi_oe, s0_oe, tb_oe;
  int   errors = 0, comparisons = 0, run_len = 0;
  int   exp_q[$], tol_q[$];
  always #12.5 ref_clk = !ref_clk;
  lrbt_far_src lrbt_far_src_i (.ref_clk(ref_clk), .run(run_clk), .clk_o(ext_clk));
  lrbt_timer lrbt_timer_i (.ref_clk(ref_clk), .rst_n(rst_n), .trigger_in(trigger_in),
    .reset_in(reset_in), .feedback_link_switch(fb_sw), .continuous_mode(cont_md),
    .ext_clock_sel(ext_sel), .time_base_in(ext_clk), .output_interval_o(),
    .output_interval_oe(oi_oe), .stage0_o(), .stage0_oe(s0_oe), .time_base_o(),
    .time_base_oe(tb_oe));
  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input int exp, tol);
    comparisons++;
    if ((got + tol >= exp && got <= exp + tol) !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t got %0d want %0d", $time, got, exp);
    end
  endtask
  // control pulses wide and spaced by three cycles
  task automatic pulse(input logic t, r);
    @(posedge ref_clk) #1;
    trigger_in = t;
    reset_in = r;
    repeat (3) @(posedge ref_clk);
    #1;
    trigger_in = 0;
    reset_in = 0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic note(input int exp, tol);
    exp_q.push_back(exp);
    tol_q.push_back(tol);
  endtask
  // bounded wait until every noted stretch is seen
  task automatic drain;
    for (int i = 0; i < 12000 && exp_q.size() > 0; i++) @(posedge ref_clk);
    if (exp_q.size() > 0) begin
      chk(16'(exp_q.size()), 0, 0);
      summarize();
    end
    repeat (20) @(posedge ref_clk);
    #1;
  endtask
  // watcher: each low stretch of the timing pin against the oldest note
  always @(posedge ref_clk) begin
    if (oi_oe === 1'b1)
      run_len++;
    else if (run_len > 0) begin
      if (exp_q.size() == 0)
        chk(16'hffff, 0, 0);
      else
        chk(16'(run_len), exp_q.pop_front(), tol_q.pop_front());
      run_len = 0;
    end
  end
  initial begin
    void'($urandom(32'hddcd));
    repeat (6) @(posedge ref_clk);
    #1;
    rst_n = 1;
    note(1018, 8);
    note(1024, 1);
    drain();
    cont_md = 0;
    pulse(0, 1);
    chk({oi_oe, s0_oe, tb_oe}, 0, 0);
    run_clk = 0;
    ext_sel = 0;
    fb_sw = 1;
    repeat ($urandom_range(20, 3)) @(posedge ref_clk);
    note(10240, 2);
    pulse(1, 0);
    repeat (3000) @(posedge ref_clk);
    pulse(1, 0);
    drain();
    chk({oi_oe, s0_oe, tb_oe}, 0, 0);
    note(10240, 2);
    pulse(1, 1);
    drain();
    chk({oi_oe, s0_oe, tb_oe}, 0, 0);
    summarize();
  end
endmodule
`default_nettype wire
